// File: sdram_seq_pkg.sv
/*
  sdram_seq_pkg: shared constants for the read-after-write sequencer.
  assumes a 100 MHz controller clock; memory timings are given in cycles.
*/
package sdram_seq_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // default memory timings in clock cycles
  localparam int T_WR_CYC  = 3;
  localparam int T_RP_CYC  = 3;
  localparam int T_RCD_CYC = 3;
  localparam int T_WTR_CYC = 2;
  localparam int CAS_CYC   = 3;

  localparam int BANK_W = 2;
  localparam int ROW_W  = 13;
  localparam int COL_W  = 10;
  localparam int CNT_W  = 8;

  // command encodings on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE   = 4'h2;

  // address bit that selects precharge of all banks; held low to precharge only the addressed bank
  localparam int A10_POS = 10;

endpackage : sdram_seq_pkg

// File: gap_timer.sv
/*
  gap_timer: down counter that reports when a loaded interval has elapsed.
  assumes load and the loaded count are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module gap_timer #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] count_in,
  output logic                  done_out
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (load_in) begin
      cnt_r <= count_in;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done_out = (cnt_r == '0) && !load_in;
endmodule : gap_timer
`default_nettype wire

// File: bank_row_table.sv
/*
  bank_row_table: open-row record for each bank, flip-flop storage.
  assumes one open or close update per cycle at most.
*/
`timescale 1ns/1ps
`default_nettype none
module bank_row_table #(
  parameter int BANK_W = 2,
  parameter int ROW_W  = 13
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              open_in,
  input  wire logic              close_in,
  input  wire logic [BANK_W-1:0] bank_in,
  input  wire logic [ROW_W-1:0]  row_in,
  output logic                   is_open_out,
  output logic [ROW_W-1:0]       open_row_out
);
  localparam int NBANK = 1 << BANK_W;
  logic             valid_r [NBANK];
  logic [ROW_W-1:0] row_r   [NBANK];

  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          valid_r[g] <= 1'b0;
          row_r[g]   <= '0;
        end else if (bank_in == BANK_W'(g)) begin
          if (open_in) begin
            valid_r[g] <= 1'b1;
            row_r[g]   <= row_in;
          end else if (close_in) begin
            valid_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign is_open_out  = valid_r[bank_in];
  assign open_row_out = row_r[bank_in];
endmodule : bank_row_table
`default_nettype wire

// File: sdram_read_after_write_sequencer.sv
/*
  sdram_read_after_write_sequencer: issues write, precharge, activate and
  read commands to an sdram with the required gaps between them.
  assumes user inputs synchronous to CORE_CLK_IN; the memory runs on the
  same clock, so one memory cycle equals one controller cycle.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - A request with its address is taken only in a cycle where request and ready are both high.
// - A read to another row of a bank holding an open row first precharges that bank.
// - The precharge waits the write recovery interval after the last write data.
// - An activate waits the row precharge interval after the precharge.
// - A read waits the activate-to-read interval after the activate.
// - Read data is expected a CAS latency after the read command.
// - A read to the same open row after a write waits the write-to-read interval.
// - A read that hits the open row issues no precharge or activate.
// - On a row change the read still holds in rd until the write-to-read interval has run out.
// - All memory timings are module parameters.
module sdram_read_after_write_sequencer #(
  parameter int T_WR  = sdram_seq_pkg::T_WR_CYC,
  parameter int T_RP  = sdram_seq_pkg::T_RP_CYC,
  parameter int T_RCD = sdram_seq_pkg::T_RCD_CYC,
  parameter int T_WTR = sdram_seq_pkg::T_WTR_CYC,
  parameter int CAS   = sdram_seq_pkg::CAS_CYC
) (
  input  wire logic                             CORE_CLK_IN,
  input  wire logic                             SYS_RST_IN,
  input  wire logic                             READ_REQ_IN,
  input  wire logic                             WRITE_REQ_IN,
  input  wire logic [sdram_seq_pkg::BANK_W-1:0] BANK_IN,
  input  wire logic [sdram_seq_pkg::ROW_W-1:0]  ROW_IN,
  input  wire logic [sdram_seq_pkg::COL_W-1:0]  COL_IN,
  output logic                                  READY_OUT,
  output logic                                  RDATA_VALID_OUT,
  output logic                                  CS_N_OUT,
  output logic                                  RAS_N_OUT,
  output logic                                  CAS_N_OUT,
  output logic                                  WE_N_OUT,
  output logic [sdram_seq_pkg::BANK_W-1:0]      MEM_BA_OUT,
  output logic [sdram_seq_pkg::ROW_W-1:0]       MEM_ADDR_OUT
);
  localparam int BW = sdram_seq_pkg::BANK_W;
  localparam int RW = sdram_seq_pkg::ROW_W;
  localparam int CW = sdram_seq_pkg::COL_W;
  localparam int NW = sdram_seq_pkg::CNT_W;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_WR, ST_PRE, ST_WAIT_RP, ST_ACT, ST_WAIT_RCD, ST_RD, ST_WR
  } state_t;

  state_t        state_r;
  logic          is_read_r;
  logic [BW-1:0] bank_r;
  logic [RW-1:0] row_r;
  logic [CW-1:0] col_r;
  logic          last_write_r;
  logic [3:0]    cmd_r;
  logic [CAS-1:0] rd_pipe_r;

  logic          accept;
  logic          row_open;
  logic [RW-1:0] open_row;
  logic          wr_done;
  logic          wtr_done;
  logic          gap_done;
  logic          gap_load;
  logic [NW-1:0] gap_count;
  logic          tbl_open;
  logic          tbl_close;
  logic          rd_go;
  logic          row_hit;

  function automatic logic [NW-1:0] cyc(input int n);
    cyc = (n > 1) ? NW'(n - 1) : '0;
  endfunction : cyc

  assign READY_OUT = (state_r == ST_IDLE);
  assign accept    = READY_OUT && (READ_REQ_IN || WRITE_REQ_IN);

  // write recovery and write-to-read both start at the write command
  gap_timer #(.CNT_W(NW)) u_wr_timer (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (SYS_RST_IN),
    .load_in  (state_r == ST_WR),
    .count_in (cyc(T_WR + 1)),
    .done_out (wr_done)
  );

  gap_timer #(.CNT_W(NW)) u_wtr_timer (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (SYS_RST_IN),
    .load_in  (state_r == ST_WR),
    .count_in (cyc(T_WTR + 1)),
    .done_out (wtr_done)
  );

  gap_timer #(.CNT_W(NW)) u_gap_timer (
    .clk_in   (CORE_CLK_IN),
    .rst_in   (SYS_RST_IN),
    .load_in  (gap_load),
    .count_in (gap_count),
    .done_out (gap_done)
  );

  assign gap_load  = (state_r == ST_PRE) || (state_r == ST_ACT);
  assign gap_count = (state_r == ST_PRE) ? cyc(T_RP) : cyc(T_RCD);

  assign tbl_open  = (state_r == ST_ACT);
  assign tbl_close = (state_r == ST_PRE);

  // same-row read after a write holds off until write-to-read has run out
  assign rd_go   = !last_write_r || wtr_done;
  assign row_hit = row_open && (open_row == ROW_IN);

  bank_row_table #(.BANK_W(BW), .ROW_W(RW)) u_rows (
    .clk_in       (CORE_CLK_IN),
    .rst_in       (SYS_RST_IN),
    .open_in      (tbl_open),
    .close_in     (tbl_close),
    .bank_in      (state_r == ST_IDLE ? BANK_IN : bank_r),
    .row_in       (row_r),
    .is_open_out  (row_open),
    .open_row_out (open_row)
  );

  // address is held from the take to the end of the sequence
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      bank_r <= '0;
      row_r  <= '0;
      col_r  <= '0;
    end else if (accept) begin
      bank_r <= BANK_IN;
      row_r  <= ROW_IN;
      col_r  <= COL_IN;
    end
  end

  // read wins when both requests stand in the same cycle
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      is_read_r <= 1'b0;
    end else if (accept) begin
      is_read_r <= READ_REQ_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      last_write_r <= 1'b0;
    end else if (state_r == ST_WR) begin
      last_write_r <= 1'b1;
    end else if (state_r == ST_RD && rd_go) begin
      // cleared only once the read leaves, so a long write-to-read is kept whole
      last_write_r <= 1'b0;
    end
  end

  // idle waits for a take; wait_wr lets write recovery run out; pre and act
  // stand one cycle each and load the gap timer; wait_rp and wait_rcd sit on
  // that timer; rd holds until the read may go; wr issues the write
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            if (row_hit) begin
              state_r <= READ_REQ_IN ? ST_RD : ST_WR;
            end else if (row_open) begin
              state_r <= ST_WAIT_WR;
            end else begin
              state_r <= ST_ACT;
            end
          end
        end
        ST_WAIT_WR: begin
          if (wr_done) begin
            state_r <= ST_PRE;
          end
        end
        ST_PRE: begin
          state_r <= ST_WAIT_RP;
        end
        ST_WAIT_RP: begin
          if (gap_done) begin
            state_r <= ST_ACT;
          end
        end
        ST_ACT: begin
          state_r <= ST_WAIT_RCD;
        end
        // no write-to-read wait here; precharge plus activate cover it
        ST_WAIT_RCD: begin
          if (gap_done) begin
            state_r <= is_read_r ? ST_RD : ST_WR;
          end
        end
        ST_RD: begin
          if (rd_go) begin
            state_r <= ST_IDLE;
          end
        end
        ST_WR: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      cmd_r <= sdram_seq_pkg::CMD_NOP;
    end else begin
      case (state_r)
        ST_PRE:  cmd_r <= sdram_seq_pkg::CMD_PRE;
        ST_ACT:  cmd_r <= sdram_seq_pkg::CMD_ACT;
        ST_RD:   cmd_r <= rd_go ? sdram_seq_pkg::CMD_READ : sdram_seq_pkg::CMD_NOP;
        ST_WR:   cmd_r <= sdram_seq_pkg::CMD_WRITE;
        default: cmd_r <= sdram_seq_pkg::CMD_NOP;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      MEM_BA_OUT <= '0;
    end else begin
      MEM_BA_OUT <= bank_r;
    end
  end

  // row on activate, column on read or write; zero keeps precharge to one bank
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      MEM_ADDR_OUT <= '0;
    end else begin
      case (state_r)
        ST_ACT:  MEM_ADDR_OUT <= row_r;
        ST_RD:   MEM_ADDR_OUT <= rd_go ? RW'(col_r) : '0;
        ST_WR:   MEM_ADDR_OUT <= RW'(col_r);
        default: MEM_ADDR_OUT <= '0;
      endcase
    end
  end

  assign CS_N_OUT  = cmd_r[3];
  assign RAS_N_OUT = cmd_r[2];
  assign CAS_N_OUT = cmd_r[1];
  assign WE_N_OUT  = cmd_r[0];

  // read data window: cas cycles after the read command leaves the pins
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      rd_pipe_r <= '0;
    end else begin
      rd_pipe_r <= {rd_pipe_r[CAS-2:0], cmd_r == sdram_seq_pkg::CMD_READ};
    end
  end

  assign RDATA_VALID_OUT = rd_pipe_r[CAS-1];
endmodule : sdram_read_after_write_sequencer
`default_nettype wire

// File: sdram_seq_properties.sv
/* sdram_seq_properties: timing checks on the sequencer's memory pins.
   assumes it is bound to the sequencer top and the memory clock is the core clock. */
`timescale 1ns/1ps
`default_nettype none
module sdram_seq_properties #(
  parameter int CAS = 3
) (
  input wire logic                            CORE_CLK_IN,
  input wire logic                            SYS_RST_IN,
  input wire logic                            READ_REQ_IN,
  input wire logic                            WRITE_REQ_IN,
  input wire logic                            READY_OUT,
  input wire logic                            RDATA_VALID_OUT,
  input wire logic                            CS_N_OUT,
  input wire logic                            RAS_N_OUT,
  input wire logic                            CAS_N_OUT,
  input wire logic                            WE_N_OUT,
  input wire logic [sdram_seq_pkg::ROW_W-1:0] MEM_ADDR_OUT
);
  wire logic [3:0] cmd = {CS_N_OUT, RAS_N_OUT, CAS_N_OUT, WE_N_OUT};
  wire logic       rd  = cmd == sdram_seq_pkg::CMD_READ;
  wire logic       wr  = cmd == sdram_seq_pkg::CMD_WRITE;
  wire logic       act = cmd == sdram_seq_pkg::CMD_ACT;
  wire logic       pre = cmd == sdram_seq_pkg::CMD_PRE;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // past depths follow the default timings; a retimed build needs new depths
  reset_idle_a: assert property (disable iff (1'b0) SYS_RST_IN |=> READY_OUT && !rd && !wr && !act && !pre)
    else $error("not idle after reset");
  take_drop_a: assert property (READY_OUT && (READ_REQ_IN || WRITE_REQ_IN) |=> !READY_OUT)
    else $error("ready stayed high after a take");
  read_issue_a: assert property (READY_OUT && READ_REQ_IN |=> ##[1:40] rd)
    else $error("taken read never issued");
  pre_single_a: assert property (pre |-> !MEM_ADDR_OUT[sdram_seq_pkg::A10_POS])
    else $error("precharge not limited to one bank");
  wr_recover_a: assert property (pre |-> !$past(wr) && !$past(wr, 2) && !$past(wr, 3))
    else $error("precharge too soon after write");
  pre_gap_a: assert property (act |-> !$past(pre) && !$past(pre, 2) && !$past(pre, 3))
    else $error("activate too soon after precharge");
  rcd_gap_a: assert property (rd |-> !$past(act) && !$past(act, 2) && !$past(act, 3))
    else $error("read too soon after activate");
  cas_valid_a: assert property (rd |-> ##CAS RDATA_VALID_OUT)
    else $error("read data valid missing");
  valid_cause_a: assert property (RDATA_VALID_OUT |-> $past(rd, CAS))
    else $error("read data valid without a read");
  wtr_gap_a: assert property (rd |-> !$past(wr) && !$past(wr, 2))
    else $error("read right after write");
  cover property (pre ##[1:10] act ##[1:10] rd);
  cover property (wr ##[1:10] rd);
  cover property (RDATA_VALID_OUT);
endmodule : sdram_seq_properties
`default_nettype wire

// File: sdram_model.sv
/* sdram_model: memory device watching the command pins, with read data timing.
   assumes commands registered on the rising edge of the shared clock. */
`timescale 1ns/1ps
`default_nettype none
module sdram_model #(
  parameter int CAS = 3
) (
  input  wire logic                             clk_in,
  input  wire logic                             rst_in,
  input  wire logic [3:0]                       cmd_in,
  input  wire logic [sdram_seq_pkg::BANK_W-1:0] ba_in,
  output logic                                  valid_out,
  output logic                                  fault_out
);
  logic [3:0]     open_r;
  logic [CAS-1:0] rd_r;
  assign valid_out = rd_r[CAS-1];
  always_ff @(posedge clk_in) begin
    if (rst_in) rd_r <= '0;
    else rd_r <= {rd_r[CAS-2:0], cmd_in == sdram_seq_pkg::CMD_READ};
  end
  // real parts corrupt silently, so an activate to an open bank and a read or write to a closed bank are flagged
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      open_r <= 4'h0;
      fault_out <= 1'b0;
    end else begin
      fault_out <= 1'b0;
      case (cmd_in)
        sdram_seq_pkg::CMD_ACT: begin
          fault_out <= open_r[ba_in];
          open_r[ba_in] <= 1'b1;
        end
        sdram_seq_pkg::CMD_PRE: open_r[ba_in] <= 1'b0;
        sdram_seq_pkg::CMD_READ, sdram_seq_pkg::CMD_WRITE: fault_out <= !open_r[ba_in];
        default: ;
      endcase
    end
  end
endmodule : sdram_model
`default_nettype wire

// File: sdram_read_after_write_sequencer_tb.sv
/* sdram_read_after_write_sequencer_tb: directed and random reads and writes.
   assumes default timings; the memory model shares the core clock. */
`timescale 1ns/1ps
`default_nettype none
module sdram_read_after_write_sequencer_tb;
  typedef struct {logic [3:0] cmd; logic [1:0] ba; logic [12:0] addr; logic [12:0] row; logic [1:0] pre;
                  logic [1:0] act;} note_t;
  logic        clk, rst, read_req, write_req, ready, rvalid, cs_n, ras_n, cas_n, we_n, mvalid, mfault, both;
  logic [1:0]  bank, ba;
  logic [12:0] row, addr;
  logic [9:0]  col;
  logic [3:0]  open_r;
  logic [12:0] row_r [4];
  int          checks = 0, failures = 0, npre = 0, nact = 0, seed = 32'hb83dbe8d;
  note_t       notes[$];
  note_t       got;
  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  sdram_read_after_write_sequencer sdram_read_after_write_sequencer_i (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
    .READ_REQ_IN(read_req), .WRITE_REQ_IN(write_req), .BANK_IN(bank), .ROW_IN(row), .COL_IN(col), .READY_OUT(ready),
    .RDATA_VALID_OUT(rvalid), .CS_N_OUT(cs_n), .RAS_N_OUT(ras_n), .CAS_N_OUT(cas_n), .WE_N_OUT(we_n),
    .MEM_BA_OUT(ba), .MEM_ADDR_OUT(addr));
  sdram_model sdram_model_i (.clk_in(clk), .rst_in(rst), .cmd_in(cmd), .ba_in(ba), .valid_out(mvalid),
    .fault_out(mfault));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // request held until taken; the expected pin sequence is noted at the take
  task automatic req(input logic rd, input logic [1:0] b, input logic [12:0] r, input logic [9:0] c);
    note_t t;
    t = '{rd ? sdram_seq_pkg::CMD_READ : sdram_seq_pkg::CMD_WRITE, b, {3'h0, c}, r,
          {1'b0, open_r[b] && row_r[b] != r}, {1'b0, !open_r[b] || row_r[b] != r}};
    open_r[b] = 1'b1;
    row_r[b] = r;
    @(posedge clk);
    read_req <= rd;
    write_req <= !rd || both;
    bank <= b;
    row <= r;
    col <= c;
    do @(negedge clk); while (ready !== 1'b1);
    notes.push_back(t);
    @(posedge clk);
    read_req <= 1'b0;
    write_req <= 1'b0;
  endtask : req
  always @(negedge clk) begin
    if (!rst) begin
      chk("rdata valid", 16'(rvalid), 16'(mvalid));
      chk("memory fault", 16'(mfault), 16'h0);
      npre += int'(cmd == sdram_seq_pkg::CMD_PRE);
      nact += int'(cmd == sdram_seq_pkg::CMD_ACT);
      if (cmd == sdram_seq_pkg::CMD_ACT && notes.size() > 0) chk("row", 16'(addr), 16'(notes[0].row));
      if (cmd == sdram_seq_pkg::CMD_READ || cmd == sdram_seq_pkg::CMD_WRITE) begin
        if (notes.size() == 0) chk("spare command", 16'(cmd), 16'h7);
        else begin
          got = notes.pop_front();
          chk("command", 16'(cmd), 16'(got.cmd));
          chk("bank", 16'(ba), 16'(got.ba));
          chk("column", 16'(addr), 16'(got.addr));
          chk("precharges", 16'(npre), 16'(got.pre));
          chk("activates", 16'(nact), 16'(got.act));
        end
        npre = 0;
        nact = 0;
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    {read_req, write_req, both, bank, row, col} = '0;
    open_r = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    req(1'b0, 2'h0, 13'h5, 10'h1);
    req(1'b1, 2'h0, 13'h5, 10'h2);
    $display("row hit test done");
    req(1'b0, 2'h0, 13'h5, 10'h4);
    req(1'b1, 2'h0, 13'h9, 10'h3);
    req(1'b1, 2'h2, 13'h9, 10'h3ff);
    $display("row change test done");
    repeat (60) req(1'($random(seed)), 2'($random(seed)), 13'($random(seed)) & 13'h1, 10'($random(seed)));
    $display("random mix test done");
    repeat (40) @(posedge clk);
    chk("pending notes", 16'(notes.size()), 16'h0);
    // mid-run reset closes every row; the next read also has both requests up
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    open_r = 4'h0;
    both = 1'b1;
    req(1'b1, 2'h0, 13'h1, 10'h6);
    both = 1'b0;
    $display("reset and dual request test done");
    repeat (30) @(posedge clk);
    chk("pending notes", 16'(notes.size()), 16'h0);
    close_out();
  end
endmodule : sdram_read_after_write_sequencer_tb
bind sdram_read_after_write_sequencer sdram_seq_properties #(.CAS(CAS)) sdram_seq_properties_i (.CORE_CLK_IN,
  .SYS_RST_IN, .READ_REQ_IN, .WRITE_REQ_IN, .READY_OUT, .RDATA_VALID_OUT, .CS_N_OUT, .RAS_N_OUT, .CAS_N_OUT,
  .WE_N_OUT, .MEM_ADDR_OUT);
`default_nettype wire
